// *** pkg/pwm_pkg.sv ***
// Constants and types shared by the 16-bit PWM timer
// Function
// - Fast PWM counts up from BOTTOM to TOP, then restarts at BOTTOM.
// - Fast PWM TOP is fixed 0x00FF/0x01FF/0x03FF, capture-top or compare A.
// - Fast non-inverting sets output on match, clears at TOP; inverting opposite.
// - Output mode two is non-inverted PWM, three is inverted PWM.
// - Fast PWM raises the overflow flag each time the counter reaches TOP.
// - Fast PWM compare A or capture flag rises with overflow when that register is TOP.
// - Capture-top is unbuffered; written below count, counter wraps through 0xFFFF.
// - Fast PWM compare A is buffered and loaded when the counter matches TOP.
// - Fixed TOP modes zero compare bits above the resolution on every write.
// - TOP stays at or above every compare value, else no match occurs.
// - Fast compare zero gives narrow pulse; compare equal TOP gives constant level.
// - Fast PWM output mode one toggles channel A on match, buffering kept.
// - Waveform reaches the pin only with direction output and route enable set.
// - Phase-correct counts up BOTTOM to TOP, then down to BOTTOM.
// - Phase-correct TOP is fixed, capture-top or compare A; held one cycle.
// - Phase non-inverting clears on up-match, sets on down-match; inverting opposite.
// - Phase-correct raises the overflow flag each time the counter reaches BOTTOM.
// - Phase-correct loads compare buffers at TOP, with compare A or capture flag.
// - Phase compare BOTTOM gives constant low, TOP constant high, non-inverted.
// - Each compare flag rises whenever the counter matches that compare value.
// - Output mode zero leaves the output state unchanged at matches.
// - Output compare state of each channel clears on reset.
// - Counter, flags and PWM buffer loads advance only on timer clock enable; non-PWM modes load the buffers every clock.
package pwm_pkg;
   // -------------------------------------------------
   // Register offsets
   // -------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] CMP_A_OFS = 8'h04;
   localparam logic [7:0] CMP_B_OFS = 8'h08;
   localparam logic [7:0] CAP_TOP_OFS = 8'h0C;
   localparam logic [7:0] COUNT_OFS = 8'h10;
   localparam logic [7:0] FLAGS_OFS = 8'h14;
   // -------------------------------------------------
   // Field positions
   // -------------------------------------------------
   localparam int MODE_LSB = 0;
   localparam int OUT_A_LSB = 4;
   localparam int OUT_B_LSB = 6;
   localparam int ROUTE_A_BIT = 8;
   localparam int ROUTE_B_BIT = 9;
   localparam int DIR_A_BIT = 10;
   localparam int DIR_B_BIT = 11;
   localparam int CTRL_W = 12;
   localparam int OVF_BIT = 0;
   localparam int MATCH_A_BIT = 1;
   localparam int MATCH_B_BIT = 2;
   localparam int CAPT_BIT = 3;
   // -------------------------------------------------
   // Reset values and count limits
   // -------------------------------------------------
   localparam logic [11:0] CTRL_RST = 12'h000;
   localparam logic [15:0] VAL_RST = 16'h0000;
   localparam logic [3:0] FLAGS_RST = 4'h0;
   localparam logic [15:0] BOTTOM = 16'h0000;
   localparam logic [15:0] MAX = 16'hFFFF;
   localparam logic [15:0] TOP_8BIT = 16'h00FF;
   localparam logic [15:0] TOP_9BIT = 16'h01FF;
   localparam logic [15:0] TOP_10BIT = 16'h03FF;
   // -------------------------------------------------
   // Waveform mode codes and output modes
   // -------------------------------------------------
   localparam logic [3:0] PC_8BIT = 4'h1;
   localparam logic [3:0] PC_9BIT = 4'h2;
   localparam logic [3:0] PC_10BIT = 4'h3;
   localparam logic [3:0] FAST_8BIT = 4'h5;
   localparam logic [3:0] FAST_9BIT = 4'h6;
   localparam logic [3:0] FAST_10BIT = 4'h7;
   localparam logic [3:0] PC_CAP_TOP = 4'hA;
   localparam logic [3:0] PC_CMP_TOP = 4'hB;
   localparam logic [3:0] FAST_CAP_TOP = 4'hE;
   localparam logic [3:0] FAST_CMP_TOP = 4'hF;
   typedef enum logic [1:0] {OUT_NONE, OUT_TOGGLE, OUT_NONINV, OUT_INV} out_mode_t;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pwm_pkg

// *** pkg/timer_link_if.sv ***
// Counter state shared from the timer core to the compare channels
`timescale 1ns/100ps
interface timer_link_if;
   logic tick;
   logic [15:0] count;
   logic top_hit;
   logic dir_up;
   logic fast;
   logic phase;
   modport timer (output tick, count, top_hit, dir_up, fast, phase);
   modport chan (input tick, count, top_hit, dir_up, fast, phase);
endinterface : timer_link_if

// *** hw/pwm_chan.sv ***
// One compare channel: match detection and output compare state
`timescale 1ns/100ps
module pwm_chan (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Counter state
   timer_link_if.chan link,
   // Channel setup
   input wire logic [15:0] compare,
   input wire logic [1:0] out_mode,
   input wire logic toggle_ok,
   // Channel results
   output logic match,
   output logic oc
);
   logic oc_reg;
   logic oc_next;
   logic inv;

   assign oc = oc_reg;

   // -------------------------------------------------
   // Match and output action
   // -------------------------------------------------
   always_comb begin
      inv = (out_mode == pwm_pkg::OUT_INV);
      match = link.tick && (link.count == compare);
      oc_next = oc_reg;
      if (link.fast) begin
         if (out_mode[1]) begin
            // set at match, clear at TOP
            if (match) begin
               oc_next = ~inv;
            end else if (link.top_hit) begin
               oc_next = inv;
            end
         end else if (out_mode == pwm_pkg::OUT_TOGGLE && toggle_ok && match) begin
            oc_next = ~oc_reg;
         end
      end else if (link.phase && out_mode[1] && match) begin
         if (link.count == pwm_pkg::BOTTOM) begin
            oc_next = inv;
         end else if (link.top_hit) begin
            oc_next = ~inv;
         end else begin
            oc_next = link.dir_up ? inv : ~inv;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         oc_reg <= 1'b0;
      end else begin
         oc_reg <= oc_next;
      end
   end
endmodule : pwm_chan

// *** hw/timer16_pwm.sv ***
// Top of the 16-bit PWM timer with its AXI4-Lite register slave
//
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
module timer16_pwm #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RESET_N,
   // Prescaled timer clock enable
   input wire logic TIMER_TICK,
   // AXI4-Lite write address
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic [2:0] S_AXI_AWPROT,
   // AXI4-Lite write data
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   // AXI4-Lite write response
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   output logic [1:0] S_AXI_BRESP,
   // AXI4-Lite read address
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic [2:0] S_AXI_ARPROT,
   // AXI4-Lite read data
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   // Port pin drivers
   output logic WAVE_OUT_A,
   output logic WAVE_OUT_A_OE,
   output logic WAVE_OUT_B,
   output logic WAVE_OUT_B_OE
);
   timer_link_if link ();

   // -------------------------------------------------
   // Declarations
   // -------------------------------------------------
   logic [11:0] ctrl_reg, ctrl_next;
   logic [15:0] cmp_a_buf_reg, cmp_a_buf_next;
   logic [15:0] cmp_b_buf_reg, cmp_b_buf_next;
   logic [15:0] cmp_a_reg, cmp_a_next;
   logic [15:0] cmp_b_reg, cmp_b_next;
   logic [15:0] cap_top_reg, cap_top_next;
   logic [15:0] count_reg, count_next;
   logic dir_up_reg, dir_up_next;
   logic [3:0] flags_reg, flags_next;
   logic [3:0] flag_set;
   logic aw_have_reg, aw_have_next;
   logic w_have_reg, w_have_next;
   logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
   logic [31:0] w_data_reg, w_data_next;
   logic [3:0] w_strb_reg, w_strb_next;
   logic bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next;
   logic [3:0] pins_reg, pins_next;
   logic [3:0] mode;
   logic [1:0] out_a, out_b;
   logic fast, phase, fixed_top;
   logic [15:0] top_val, fixed_mask;
   logic at_top, at_bottom, load;
   logic do_write, do_read;
   logic [31:0] wr_val;
   logic [15:0] wr_cmp;
   logic match_a, match_b, oc_a, oc_b;

   assign mode = ctrl_reg[pwm_pkg::MODE_LSB +: 4];
   assign out_a = ctrl_reg[pwm_pkg::OUT_A_LSB +: 2];
   assign out_b = ctrl_reg[pwm_pkg::OUT_B_LSB +: 2];

   // -------------------------------------------------
   // Mode decode and TOP selection
   // -------------------------------------------------
   always_comb begin
      fast = 1'b0;
      phase = 1'b0;
      fixed_top = 1'b1;
      top_val = pwm_pkg::MAX;
      unique case (mode)
         pwm_pkg::PC_8BIT, pwm_pkg::FAST_8BIT: top_val = pwm_pkg::TOP_8BIT;
         pwm_pkg::PC_9BIT, pwm_pkg::FAST_9BIT: top_val = pwm_pkg::TOP_9BIT;
         pwm_pkg::PC_10BIT, pwm_pkg::FAST_10BIT: top_val = pwm_pkg::TOP_10BIT;
         pwm_pkg::PC_CAP_TOP, pwm_pkg::FAST_CAP_TOP: begin
            top_val = cap_top_reg;
            fixed_top = 1'b0;
         end
         pwm_pkg::PC_CMP_TOP, pwm_pkg::FAST_CMP_TOP: begin
            top_val = cmp_a_reg;
            fixed_top = 1'b0;
         end
         default: fixed_top = 1'b0;
      endcase
      unique case (mode)
         pwm_pkg::FAST_8BIT, pwm_pkg::FAST_9BIT, pwm_pkg::FAST_10BIT,
         pwm_pkg::FAST_CAP_TOP, pwm_pkg::FAST_CMP_TOP: fast = 1'b1;
         pwm_pkg::PC_8BIT, pwm_pkg::PC_9BIT, pwm_pkg::PC_10BIT,
         pwm_pkg::PC_CAP_TOP, pwm_pkg::PC_CMP_TOP: phase = 1'b1;
         default: fast = 1'b0;
      endcase
      fixed_mask = fixed_top ? top_val : pwm_pkg::MAX;
   end

   assign at_top = (count_reg == top_val);
   assign at_bottom = (count_reg == pwm_pkg::BOTTOM);
   assign load = TIMER_TICK && at_top && (fast || phase);

   assign link.tick = TIMER_TICK;
   assign link.count = count_reg;
   assign link.top_hit = TIMER_TICK && at_top;
   assign link.dir_up = dir_up_reg;
   assign link.fast = fast;
   assign link.phase = phase;

   // -------------------------------------------------
   // Counter
   // -------------------------------------------------
   always_comb begin
      count_next = count_reg;
      dir_up_next = phase ? dir_up_reg : 1'b1;
      if (TIMER_TICK) begin
         if (fast) begin
            count_next = at_top ? pwm_pkg::BOTTOM : count_reg + 16'h0001;
         end else if (phase) begin
            // dual slope, TOP held one cycle
            if (dir_up_reg) begin
               if (at_top && !at_bottom) begin
                  count_next = count_reg - 16'h0001;
                  dir_up_next = 1'b0;
               end else begin
                  count_next = count_reg + 16'h0001;
               end
            end else if (at_bottom) begin
               count_next = count_reg + 16'h0001;
               dir_up_next = 1'b1;
            end else begin
               count_next = count_reg - 16'h0001;
            end
         end else begin
            count_next = count_reg + 16'h0001;
         end
      end
   end

   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         count_reg <= pwm_pkg::VAL_RST;
         dir_up_reg <= 1'b1;
      end else begin
         count_reg <= count_next;
         dir_up_reg <= dir_up_next;
      end
   end

   // -------------------------------------------------
   // Compare channels
   // -------------------------------------------------
   pwm_chan chan_a (
      .clk(REF_CLK),
      .reset_n(RESET_N),
      .link(link),
      .compare(cmp_a_reg),
      .out_mode(out_a),
      .toggle_ok(1'b1),
      .match(match_a),
      .oc(oc_a)
   );

   pwm_chan chan_b (
      .clk(REF_CLK),
      .reset_n(RESET_N),
      .link(link),
      .compare(cmp_b_reg),
      .out_mode(out_b),
      .toggle_ok(1'b0),
      .match(match_b),
      .oc(oc_b)
   );

   // -------------------------------------------------
   // Bus handshake
   // -------------------------------------------------
   assign do_write = aw_have_reg && w_have_reg && !bvalid_reg;
   assign do_read = S_AXI_ARVALID && !rvalid_reg;

   always_comb begin
      aw_have_next = aw_have_reg;
      aw_addr_next = aw_addr_reg;
      w_have_next = w_have_reg;
      w_data_next = w_data_reg;
      w_strb_next = w_strb_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      if (S_AXI_AWVALID && !aw_have_reg) begin
         aw_have_next = 1'b1;
         aw_addr_next = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !w_have_reg) begin
         w_have_next = 1'b1;
         w_data_next = S_AXI_WDATA;
         w_strb_next = S_AXI_WSTRB;
      end
      if (bvalid_reg && S_AXI_BREADY) begin
         bvalid_next = 1'b0;
      end
      if (do_write) begin
         aw_have_next = 1'b0;
         w_have_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = pwm_pkg::RESP_OKAY;
         if (aw_addr_reg[1:0] != 2'h0 || aw_addr_reg > ADDR_W'(pwm_pkg::FLAGS_OFS)) begin
            bresp_next = pwm_pkg::RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         aw_have_reg <= 1'b0;
         aw_addr_reg <= '0;
         w_have_reg <= 1'b0;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= pwm_pkg::RESP_OKAY;
      end else begin
         aw_have_reg <= aw_have_next;
         aw_addr_reg <= aw_addr_next;
         w_have_reg <= w_have_next;
         w_data_reg <= w_data_next;
         w_strb_reg <= w_strb_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
      end
   end

   // -------------------------------------------------
   // Register writes, buffers and flags
   // -------------------------------------------------
   always_comb begin
      ctrl_next = ctrl_reg;
      cmp_a_buf_next = cmp_a_buf_reg;
      cmp_b_buf_next = cmp_b_buf_reg;
      cap_top_next = cap_top_reg;
      cmp_a_next = cmp_a_reg;
      cmp_b_next = cmp_b_reg;
      flag_set = 4'h0;
      wr_val = 32'h00000000;
      for (int i = 0; i < 4; i++) begin
         wr_val[8*i +: 8] = w_strb_reg[i] ? w_data_reg[8*i +: 8] : 8'h00;
      end
      wr_cmp = wr_val[15:0] & fixed_mask;
      if (do_write) begin
         unique case (aw_addr_reg)
            ADDR_W'(pwm_pkg::CTRL_OFS): ctrl_next = wr_val[pwm_pkg::CTRL_W-1:0];
            ADDR_W'(pwm_pkg::CMP_A_OFS): cmp_a_buf_next = wr_cmp;
            ADDR_W'(pwm_pkg::CMP_B_OFS): cmp_b_buf_next = wr_cmp;
            ADDR_W'(pwm_pkg::CAP_TOP_OFS): cap_top_next = wr_val[15:0];
            default: ctrl_next = ctrl_reg;
         endcase
      end
      if (load) begin
         cmp_a_next = cmp_a_buf_reg;
         cmp_b_next = cmp_b_buf_reg;
      end else if (!fast && !phase) begin
         cmp_a_next = cmp_a_buf_reg;
         cmp_b_next = cmp_b_buf_reg;
      end
      if (TIMER_TICK) begin
         if (fast) begin
            flag_set[pwm_pkg::OVF_BIT] = at_top;
         end else if (phase) begin
            flag_set[pwm_pkg::OVF_BIT] = at_bottom && !dir_up_reg;
         end else begin
            flag_set[pwm_pkg::OVF_BIT] = (count_reg == pwm_pkg::MAX);
         end
      end
      flag_set[pwm_pkg::MATCH_A_BIT] = match_a;
      flag_set[pwm_pkg::MATCH_B_BIT] = match_b;
      // capture flag when it is TOP
      flag_set[pwm_pkg::CAPT_BIT] = load && (mode == pwm_pkg::FAST_CAP_TOP || mode == pwm_pkg::PC_CAP_TOP);
      // Write one clears, a set in the same cycle wins
      flags_next = flags_reg;
      if (do_write && aw_addr_reg == ADDR_W'(pwm_pkg::FLAGS_OFS)) begin
         flags_next = flags_reg & ~wr_val[3:0];
      end
      flags_next = flags_next | flag_set;
   end

   // values and flags reset to zero
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ctrl_reg <= pwm_pkg::CTRL_RST;
         cmp_a_buf_reg <= pwm_pkg::VAL_RST;
         cmp_b_buf_reg <= pwm_pkg::VAL_RST;
         cmp_a_reg <= pwm_pkg::VAL_RST;
         cmp_b_reg <= pwm_pkg::VAL_RST;
         cap_top_reg <= pwm_pkg::VAL_RST;
         flags_reg <= pwm_pkg::FLAGS_RST;
      end else begin
         ctrl_reg <= ctrl_next;
         cmp_a_buf_reg <= cmp_a_buf_next;
         cmp_b_buf_reg <= cmp_b_buf_next;
         cmp_a_reg <= cmp_a_next;
         cmp_b_reg <= cmp_b_next;
         cap_top_reg <= cap_top_next;
         flags_reg <= flags_next;
      end
   end

   // -------------------------------------------------
   // Register reads
   // -------------------------------------------------
   always_comb begin
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      if (rvalid_reg && S_AXI_RREADY) begin
         rvalid_next = 1'b0;
      end
      if (do_read) begin
         rvalid_next = 1'b1;
         rresp_next = pwm_pkg::RESP_OKAY;
         rdata_next = 32'h00000000;
         unique case (S_AXI_ARADDR)
            ADDR_W'(pwm_pkg::CTRL_OFS): rdata_next[pwm_pkg::CTRL_W-1:0] = ctrl_reg;
            ADDR_W'(pwm_pkg::CMP_A_OFS): rdata_next[15:0] = cmp_a_buf_reg;
            ADDR_W'(pwm_pkg::CMP_B_OFS): rdata_next[15:0] = cmp_b_buf_reg;
            ADDR_W'(pwm_pkg::CAP_TOP_OFS): rdata_next[15:0] = cap_top_reg;
            ADDR_W'(pwm_pkg::COUNT_OFS): rdata_next[15:0] = count_reg;
            ADDR_W'(pwm_pkg::FLAGS_OFS): rdata_next[3:0] = flags_reg;
            default: rresp_next = pwm_pkg::RESP_SLVERR;
         endcase
      end
   end

   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         rresp_reg <= pwm_pkg::RESP_OKAY;
      end else begin
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
      end
   end

   // -------------------------------------------------
   // Pin drive
   // -------------------------------------------------
   always_comb begin
      // visible only with direction and route set
      pins_next[0] = ctrl_reg[pwm_pkg::ROUTE_A_BIT] && oc_a;
      pins_next[1] = ctrl_reg[pwm_pkg::DIR_A_BIT] && ctrl_reg[pwm_pkg::ROUTE_A_BIT] && (out_a != 2'h0);
      pins_next[2] = ctrl_reg[pwm_pkg::ROUTE_B_BIT] && oc_b;
      pins_next[3] = ctrl_reg[pwm_pkg::DIR_B_BIT] && ctrl_reg[pwm_pkg::ROUTE_B_BIT] && (out_b != 2'h0);
   end

   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         pins_reg <= 4'h0;
      end else begin
         pins_reg <= pins_next;
      end
   end

   assign WAVE_OUT_A = pins_reg[0];
   assign WAVE_OUT_A_OE = pins_reg[1];
   assign WAVE_OUT_B = pins_reg[2];
   assign WAVE_OUT_B_OE = pins_reg[3];
   assign S_AXI_AWREADY = !aw_have_reg;
   assign S_AXI_WREADY = !w_have_reg;
   assign S_AXI_BVALID = bvalid_reg;
   assign S_AXI_BRESP = bresp_reg;
   assign S_AXI_ARREADY = !rvalid_reg;
   assign S_AXI_RVALID = rvalid_reg;
   assign S_AXI_RDATA = rdata_reg;
   assign S_AXI_RRESP = rresp_reg;
endmodule : timer16_pwm

// *** tb/pin_model.sv ***
// Pad whose released level toggles
`timescale 1ns/100ps
module pin_model (
   // Clock
   input wire logic clk,
   // Driver
   input wire logic val,
   input wire logic oe,
   // Pad
   output logic pad
);
   logic idle_reg = 1'b0;
   always_ff @(posedge clk) begin
      idle_reg <= !idle_reg;
   end
   assign pad = oe ? val : idle_reg;
endmodule : pin_model

// *** tb/timer16_pwm_chk.sv ***
// Checker bound to the timer top
`timescale 1ns/100ps
module timer16_pwm_chk (
   // Clock, reset, tick
   input wire logic REF_CLK,
   input wire logic RESET_N,
   input wire logic TIMER_TICK,
   // Bus handshakes
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic S_AXI_WVALID,
   input wire logic S_AXI_WREADY,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic S_AXI_RVALID,
   // Pins
   input wire logic WAVE_OUT_A,
   input wire logic WAVE_OUT_B
);
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RESET_N);
   // ----
   // Cycles since tick or write
   // ----
   logic [2:0] quiet_reg, quiet_next;
   always_comb begin
      quiet_next = (quiet_reg == 3'h7) ? quiet_reg : quiet_reg + 3'h1;
      if (TIMER_TICK || S_AXI_AWVALID || S_AXI_WVALID || S_AXI_BVALID) quiet_next = 3'h0;
   end
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) quiet_reg <= 3'h0;
      else quiet_reg <= quiet_next;
   end
   a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |=> ##1 S_AXI_BVALID)
      else $error("no write answer");
   a_aw_drop: assert property (S_AXI_AWVALID && S_AXI_AWREADY |=> !S_AXI_AWREADY)
      else $error("aw ready held");
   a_w_drop: assert property (S_AXI_WVALID && S_AXI_WREADY |=> !S_AXI_WREADY)
      else $error("w ready held");
   a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("no read answer");
   a_arready_block: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
      else $error("ar ready while busy");
   a_reset_pins: assert property ($rose(RESET_N) |-> !WAVE_OUT_A && !WAVE_OUT_B)
      else $error("pin high at reset");
   a_hold_pin_a: assert property (quiet_reg >= 3'h4 |-> $stable(WAVE_OUT_A))
      else $error("pin a moved idle");
   a_hold_pin_b: assert property (quiet_reg >= 3'h4 |-> $stable(WAVE_OUT_B))
      else $error("pin b moved idle");
endmodule : timer16_pwm_chk
bind timer16_pwm timer16_pwm_chk i_timer16_pwm_chk (.*);

// *** tb/tb_top.sv ***
// Self-checking bench for the PWM timer
`timescale 1ns/100ps
module tb_top;
   // ----
   // Design and pads
   // ----
   typedef struct {logic [3:0] mode; logic [15:0] top; logic [1:0] oma, omb; logic [15:0] ca, cb;} row_t;
   logic REF_CLK = 1'b0, RESET_N = 1'b0, TIMER_TICK = 1'b0;
   logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_ARVALID = 1'b0;
   logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
   logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
   logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
   logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
   logic WAVE_OUT_A, WAVE_OUT_A_OE, WAVE_OUT_B, WAVE_OUT_B_OE, pad_a, pad_b;
   int n_errors = 0, checks_done = 0;
   row_t rows [10] = '{'{4'h5, 16'h0FF, 2'h2, 2'h3, 16'h1F0, 16'h100}, '{4'h6, 16'h1FF, 2'h3, 2'h2, 16'h3FF, 16'h40},
      '{4'h7, 16'h3FF, 2'h2, 2'h2, 16'h0, 16'h200}, '{4'hE, 16'h9, 2'h1, 2'h3, 16'h3, 16'h9},
      '{4'hF, 16'h7, 2'h2, 2'h2, 16'h7, 16'h2}, '{4'h1, 16'h0FF, 2'h2, 2'h3, 16'h180, 16'h0},
      '{4'h2, 16'h1FF, 2'h3, 2'h2, 16'h1, 16'h1FF}, '{4'h3, 16'h3FF, 2'h2, 2'h3, 16'h200, 16'h3},
      '{4'hA, 16'h6, 2'h2, 2'h3, 16'h2, 16'h6}, '{4'hB, 16'h5, 2'h3, 2'h2, 16'h5, 16'h0}};
   always #20 REF_CLK = !REF_CLK;
   timer16_pwm i_timer16_pwm (.REF_CLK, .RESET_N, .TIMER_TICK, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_AWADDR,
      .S_AXI_AWPROT(3'h0), .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_WDATA, .S_AXI_WSTRB(4'hF), .S_AXI_BVALID,
      .S_AXI_BREADY(1'b1), .S_AXI_BRESP, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_ARADDR, .S_AXI_ARPROT(3'h0),
      .S_AXI_RVALID, .S_AXI_RREADY(1'b1), .S_AXI_RDATA, .S_AXI_RRESP, .WAVE_OUT_A, .WAVE_OUT_A_OE,
      .WAVE_OUT_B, .WAVE_OUT_B_OE);
   pin_model i_pin_model_a (.clk(REF_CLK), .val(WAVE_OUT_A), .oe(WAVE_OUT_A_OE), .pad(pad_a));
   pin_model i_pin_model_b (.clk(REF_CLK), .val(WAVE_OUT_B), .oe(WAVE_OUT_B_OE), .pad(pad_b));
   // ----
   // Checks and bus cycles
   // ----
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic summarize;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : summarize
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = pwm_pkg::RESP_OKAY);
      logic aw_ok, w_ok, b_ok;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= d;
      for (int i = 0; i < 40; i++) begin
         @(negedge REF_CLK);
         aw_ok = S_AXI_AWREADY;
         w_ok = S_AXI_WREADY;
         b_ok = S_AXI_BVALID;
         if (b_ok) chk("bresp", 32'(er), 32'(S_AXI_BRESP));
         @(posedge REF_CLK);
         if (aw_ok) S_AXI_AWVALID <= 1'b0;
         if (w_ok) S_AXI_WVALID <= 1'b0;
         if (b_ok) return;
      end
      n_errors++;
      summarize();
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = pwm_pkg::RESP_OKAY);
      logic ar_ok, r_ok;
      S_AXI_ARVALID <= 1'b1;
      S_AXI_ARADDR <= a;
      for (int i = 0; i < 40; i++) begin
         @(negedge REF_CLK);
         ar_ok = S_AXI_ARREADY;
         r_ok = S_AXI_RVALID;
         if (r_ok) chk("rresp", 32'(er), 32'(S_AXI_RRESP));
         d = S_AXI_RDATA;
         @(posedge REF_CLK);
         if (ar_ok) S_AXI_ARVALID <= 1'b0;
         if (r_ok) return;
      end
      n_errors++;
      summarize();
   endtask : rd
   task automatic start(input row_t r);
      RESET_N <= 1'b0;
      TIMER_TICK <= 1'b0;
      @(posedge REF_CLK);
      RESET_N <= 1'b1;
      @(posedge REF_CLK);
      wr(pwm_pkg::CTRL_OFS, {20'h0, 4'hF, r.omb, r.oma, r.mode});
      wr(pwm_pkg::CAP_TOP_OFS, {16'h0, r.top});
      wr(pwm_pkg::CMP_A_OFS, {16'h0, r.ca});
      wr(pwm_pkg::CMP_B_OFS, {16'h0, r.cb});
      TIMER_TICK <= 1'b1;
   endtask : start
   // ----
   // Expected waveform figures
   // ----
   function automatic int per(row_t r);
      per = r.mode[2] ? r.top + 1 : 2 * r.top;
   endfunction : per
   function automatic logic [15:0] eff(row_t r, logic [15:0] c);
      eff = r.mode[3] ? c : c & r.top;
   endfunction : eff
   function automatic int hi(row_t r, logic [1:0] om, logic [15:0] c);
      int h;
      h = r.mode[2] ? (eff(r, c) >= r.top ? per(r) : r.top - eff(r, c)) : 2 * eff(r, c);
      hi = om == 2'h1 ? per(r) : (om == 2'h3 ? 2 * (per(r) - h) : 2 * h);
   endfunction : hi
   // ----
   // Main sequence
   // ----
   initial begin
      logic [31:0] d, d2;
      int na, nb;
      repeat (20) @(posedge REF_CLK);
      RESET_N <= 1'b1;
      @(posedge REF_CLK);
      rd(pwm_pkg::CTRL_OFS, d);
      chk("ctrl_rst", 32'h0, d);
      rd(pwm_pkg::FLAGS_OFS, d);
      chk("flags_rst", 32'h0, d);
      rd(8'h11, d, pwm_pkg::RESP_SLVERR);
      chk("unmapped", 32'h0, d);
      wr(8'h18, 32'h1, pwm_pkg::RESP_SLVERR);
      foreach (rows[k]) begin
         start(rows[k]);
         rd(pwm_pkg::CMP_A_OFS, d);
         chk("cmp_a", {16'h0, eff(rows[k], rows[k].ca)}, d);
         repeat (2 * per(rows[k]) + 8) @(posedge REF_CLK);
         na = 0;
         nb = 0;
         repeat (2 * per(rows[k])) begin
            @(negedge REF_CLK);
            na += pad_a;
            nb += pad_b;
         end
         chk("oe", 32'h3, {30'h0, WAVE_OUT_A_OE, WAVE_OUT_B_OE});
         chk("high_a", hi(rows[k], rows[k].oma, rows[k].ca), na);
         chk("high_b", hi(rows[k], rows[k].omb, rows[k].cb), nb);
         @(posedge REF_CLK);
      end
      start('{4'hE, 16'h9, 2'h2, 2'h2, 16'h3, 16'h0});
      repeat (30) @(posedge REF_CLK);
      rd(pwm_pkg::FLAGS_OFS, d);
      chk("flags", 32'hF, d);
      TIMER_TICK <= 1'b0;
      wr(pwm_pkg::FLAGS_OFS, 32'hF);
      rd(pwm_pkg::COUNT_OFS, d);
      rd(pwm_pkg::FLAGS_OFS, d2);
      chk("flag_clear", 32'h0, d2);
      rd(pwm_pkg::COUNT_OFS, d2);
      chk("count_hold", d, d2);
      start('{4'hE, 16'h100, 2'h2, 2'h2, 16'h0, 16'h0});
      repeat (100) @(posedge REF_CLK);
      wr(pwm_pkg::CAP_TOP_OFS, 32'h3);
      rd(pwm_pkg::COUNT_OFS, d);
      chk("missed_top", 32'h1, {31'h0, d > 32'h3});
      wr(pwm_pkg::CTRL_OFS, 32'h3AE);
      repeat (4) @(posedge REF_CLK);
      @(negedge REF_CLK);
      chk("oe_off", 32'h0, {30'h0, WAVE_OUT_A_OE, WAVE_OUT_B_OE});
      summarize();
   end
endmodule : tb_top
